// file: rtl/rei_encoder_ctrl.sv
// rotary encoder and hall sensor input control
`timescale 1ns/1ps
module rei_encoder_ctrl
    import rei_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire rei_cfg_t cfg,
    input wire logic counterWipe,
    input wire logic matchRead,
    input wire logic faultRead,
    input wire logic [PHASES-1:0] phasePin,
    output rei_stat_t stat,
    output logic irq
);
    logic [PHASES-1:0] sync1;
    logic [PHASES-1:0] sync2;
    logic [PHASES-1:0] filtered;
    logic [PHASES-1:0] prevPh;
    logic [PHASES-1:0] chg;
    logic [PHASES-1:0] rise;
    logic [PHASES-1:0] hallChg;
    logic running;
    logic next_running;
    logic [DIV_W-1:0] divCnt;
    logic [DIV_W-1:0] next_div;
    logic [DIV_W-1:0] divLast;
    rei_stat_t next_stat;
    logic next_irq;
    logic cntEv;
    logic zEv;
    logic faultSet;
    logic up;
    logic divPulse;
    logic matchSet;

    // pins cross into the clock domain
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1 <= '0;
            sync2 <= '0;
            prevPh <= '0;
        end else begin
            sync1 <= phasePin;
            sync2 <= sync1;
            prevPh <= filtered;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PHASES; gi++) begin : g_filt
            rei_noise_filter u_filt (
                .ref_clk(ref_clk),
                .rst(rst),
                .widthSel(cfg.filter_width_sel),
                .din(sync2[gi]),
                .dout(filtered[gi])
            );
        end
    endgenerate

    assign chg = filtered ^ prevPh;
    assign rise = filtered & ~prevPh;
    assign hallChg = chg & {cfg.three_phase_sel, 2'h3};
    assign up = prevPh[PH_A] ^ filtered[PH_B];
    assign divLast = 8'(8'h01 << cfg.pulseDivSel) - 8'h01;

    always_comb begin
        next_stat = stat;
        next_div = divCnt;
        next_running = cfg.run & (running | ~stat.indexSeen);
        cntEv = 1'b0;
        zEv = 1'b0;
        faultSet = 1'b0;
        divPulse = 1'b0;
        matchSet = 1'b0;
        if (running && cfg.run) begin
            case (cfg.funcSel)
                MODE_ENCODER: begin
                    cntEv = chg[PH_A] | chg[PH_B];
                    faultSet = chg[PH_A] & chg[PH_B];
                    zEv = cfg.indexPhaseEn & rise[PH_Z];
                    if (cntEv && !faultSet) begin
                        next_stat.turn_direction = up;
                        next_stat.position = up ? stat.position + 24'h00_0001 : stat.position - 24'h00_0001;
                    end
                end
                MODE_SENSOR_EVT: begin
                    cntEv = |hallChg;
                    if (cntEv) begin
                        next_stat.turn_direction = up;
                        next_stat.position = stat.position + 24'h00_0001;
                    end
                end
                MODE_SENSOR_TMR: begin
                    cntEv = |hallChg;
                    next_stat.position = cntEv ? POS_RESET : stat.position + 24'h00_0001;
                end
                MODE_TIMER: begin
                    zEv = cfg.indexPhaseEn & rise[PH_Z];
                    next_stat.position = stat.position + 24'h00_0001;
                end
                default: begin
                end
            endcase
            // index edge wins over a coincident count
            if (zEv) begin
                next_stat.position = POS_RESET;
                next_stat.indexSeen = 1'b1;
            end
            if (cntEv) begin
                if (divCnt == DIV_RESET) begin
                    next_div = divLast;
                    divPulse = 1'b1;
                end else begin
                    next_div = divCnt - 8'h01;
                end
            end
            matchSet = cfg.compareEn && (stat.position == cfg.compareValue);
        end
        // a set in the same cycle as a read wins
        if (matchRead) begin
            next_stat.matchFlag = 1'b0;
        end
        if (matchSet) begin
            next_stat.matchFlag = 1'b1;
        end
        if (faultRead) begin
            next_stat.dirFault = 1'b0;
        end
        if (faultSet) begin
            next_stat.dirFault = 1'b1;
        end
        if (!cfg.run) begin
            next_div = DIV_RESET;
            next_stat.matchFlag = 1'b0;
            next_stat.dirFault = 1'b0;
            next_stat.indexSeen = 1'b0;
            next_stat.turn_direction = 1'b0;
        end
        if (counterWipe) begin
            next_stat.position = POS_RESET;
        end
        next_irq = cfg.intAllow & (divPulse | (matchSet & ~stat.matchFlag));
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stat <= '0;
            divCnt <= DIV_RESET;
            running <= 1'b0;
            irq <= 1'b0;
        end else begin
            stat <= next_stat;
            divCnt <= next_div;
            running <= next_running;
            irq <= next_irq;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence divWrap;
        running && cfg.run && cntEv && (divCnt == DIV_RESET);
    endsequence

    sequence divStep;
        running && cfg.run && cntEv && (divCnt != DIV_RESET);
    endsequence

    stop_clears_a: assert property (!cfg.run |=> !stat.matchFlag && !stat.dirFault && !stat.indexSeen
        && !stat.turn_direction && divCnt == DIV_RESET && !running)
        else $error("state not cleared after stop");
    stop_hold_a: assert property (!cfg.run && !counterWipe |=> stat.position == $past(stat.position))
        else $error("position moved while stopped");
    wipe_zero_a: assert property (counterWipe |=> stat.position == POS_RESET)
        else $error("wipe did not clear position");
    irq_gate_a: assert property (!cfg.intAllow |=> !irq)
        else $error("interrupt while not allowed");
    div_reload_a: assert property (divWrap |=> divCnt == $past(divLast) && irq == $past(cfg.intAllow))
        else $error("division counter reload wrong");
    div_step_a: assert property (divStep |=> divCnt == $past(divCnt) - 8'h01)
        else $error("division counter did not count down");
    filter_pass_a: assert property (cfg.filter_width_sel == FILT_OFF ##1 cfg.filter_width_sel == FILT_OFF
        |-> filtered == $past(sync2))
        else $error("unfiltered input not passed");
    filter_width_a: assert property ($changed(filtered[PH_A]) && $past(cfg.filter_width_sel) == 2'h1
        && $past(cfg.filter_width_sel, 31) == 2'h1 |-> $past(sync2[PH_A], 30) == filtered[PH_A])
        else $error("short pulse passed the filter");
    match_set_a: assert property (cfg.run && running && cfg.compareEn
        && stat.position == cfg.compareValue |=> stat.matchFlag)
        else $error("match flag not set");
    fault_set_a: assert property (cfg.run && running && cfg.funcSel == MODE_ENCODER
        && chg[PH_A] && chg[PH_B] |=> stat.dirFault)
        else $error("fault flag not set");
    index_keep_a: assert property (stat.indexSeen && cfg.run |=> stat.indexSeen)
        else $error("index flag lost while running");
    start_gate_a: assert property ($rose(running) |-> $past(cfg.run) && !$past(stat.indexSeen))
        else $error("started without run set and index flag clear");
endmodule

// file: rtl/rei_noise_filter.sv
// one phase input noise filter
`timescale 1ns/1ps
module rei_noise_filter
    import rei_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] widthSel,
    input wire logic din,
    output logic dout
);
    logic [FILT_W-1:0] cnt;
    logic [FILT_W-1:0] next_cnt;
    logic next_dout;
    logic [FILT_W-1:0] limit;

    always_comb begin
        case (widthSel)
            2'h1: limit = FILT_CYC_1;
            2'h2: limit = FILT_CYC_2;
            default: limit = FILT_CYC_3;
        endcase
        next_cnt = FILT_RESET;
        next_dout = dout;
        if (widthSel == FILT_OFF) begin
            next_dout = din;
        end else if (din != dout) begin
            // level must stay for the full width before it passes
            if (cnt >= limit - 7'h01) begin
                next_dout = din;
            end else begin
                next_cnt = cnt + 7'h01;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt <= FILT_RESET;
            dout <= 1'b0;
        end else begin
            cnt <= next_cnt;
            dout <= next_dout;
        end
    end
endmodule

// file: rtl/rei_pkg.sv
// constants and carrier types for the rotary encoder input control
package rei_pkg;
    localparam int POS_W = 24;
    localparam int FILT_W = 7;
    localparam int DIV_W = 8;
    localparam int PHASES = 3;
    localparam logic [POS_W-1:0] POS_RESET = 24'h00_0000;
    localparam logic [DIV_W-1:0] DIV_RESET = 8'h00;
    localparam logic [FILT_W-1:0] FILT_RESET = 7'h00;
    localparam logic [1:0] FILT_OFF = 2'h0;
    localparam logic [FILT_W-1:0] FILT_CYC_1 = 7'h1f;
    localparam logic [FILT_W-1:0] FILT_CYC_2 = 7'h3f;
    localparam logic [FILT_W-1:0] FILT_CYC_3 = 7'h7f;
    localparam logic [1:0] MODE_ENCODER = 2'h0;
    localparam logic [1:0] MODE_SENSOR_EVT = 2'h1;
    localparam logic [1:0] MODE_SENSOR_TMR = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;
    localparam int PH_A = 0;
    localparam int PH_B = 1;
    localparam int PH_Z = 2;

    typedef struct packed {
        logic run;
        logic [1:0] filter_width_sel;
        logic intAllow;
        logic [2:0] pulseDivSel;
        logic [1:0] funcSel;
        logic indexPhaseEn;
        logic three_phase_sel;
        logic compareEn;
        logic [POS_W-1:0] compareValue;
    } rei_cfg_t;

    typedef struct packed {
        logic [POS_W-1:0] position;
        logic matchFlag;
        logic dirFault;
        logic indexSeen;
        logic turn_direction;
    } rei_stat_t;
endpackage

// file: testbench/rei_encoder_ctrl_tb.sv
// self-checking bench for the rotary encoder input control
`timescale 1ns/1ps
module rei_encoder_ctrl_tb;
    import rei_pkg::*;
    typedef struct {
        logic [1:0] mode;
        logic [2:0] div;
        logic p3, ia;
        int n, pos, irqs;
    } rei_row_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    rei_cfg_t cfg = '0;
    logic counterWipe = 1'b0, matchRead = 1'b0, faultRead = 1'b0;
    logic stepUp = 1'b0, stepDown = 1'b0;
    logic [2:0] toggle = 3'h0;
    logic [PHASES-1:0] phasePin;
    rei_stat_t stat;
    logic irq;
    logic [23:0] hold;
    int failures = 0, n_checks = 0, irqCnt = 0, cycles = 0;
    rei_row_t rows[6] = '{
        '{MODE_ENCODER, 3'h0, 1'b0, 1'b1, 5, 5, 5},
        '{MODE_ENCODER, 3'h2, 1'b0, 1'b1, 9, 9, 3},
        '{MODE_ENCODER, 3'h7, 1'b0, 1'b1, 129, 129, 2},
        '{MODE_ENCODER, 3'h1, 1'b0, 1'b0, 4, 4, 0},
        '{MODE_SENSOR_EVT, 3'h0, 1'b0, 1'b0, 6, 4, 0},
        '{MODE_SENSOR_EVT, 3'h0, 1'b1, 1'b0, 6, 6, 0}
    };

    always #10 ref_clk = ~ref_clk;

    rei_encoder_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .cfg(cfg), .counterWipe(counterWipe),
        .matchRead(matchRead), .faultRead(faultRead), .phasePin(phasePin), .stat(stat), .irq(irq));
    rei_encoder_model i_enc (.ref_clk(ref_clk), .stepUp(stepUp), .stepDown(stepDown), .toggle(toggle),
        .phasePin(phasePin));

    always @(posedge ref_clk) begin
        cycles++;
        if (irq === 1'b1)
            irqCnt++;
        if (cycles == 30000) begin
            failures++;
            stop_test();
        end
    end

    function automatic logic [23:0] b(input logic x);
        return {23'h0, x};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ev(input logic up, input logic dn, input logic [2:0] tg, input int w);
        @(negedge ref_clk);
        stepUp = up;
        stepDown = dn;
        toggle = tg;
        @(negedge ref_clk);
        stepUp = 1'b0;
        stepDown = 1'b0;
        toggle = 3'h0;
        cyc(w);
    endtask
    // flag reads, with an optional position wipe
    task automatic clr(input logic w);
        counterWipe = w;
        matchRead = 1'b1;
        faultRead = 1'b1;
        cyc(1);
        counterWipe = 1'b0;
        matchRead = 1'b0;
        faultRead = 1'b0;
    endtask
    task automatic start(input logic [1:0] m, input logic z);
        cfg.run = 1'b0;
        cyc(2);
        clr(1'b1);
        cfg.funcSel = m;
        cfg.indexPhaseEn = z;
        cfg.three_phase_sel = 1'b0;
        cfg.run = 1'b1;
        cyc(3);
        irqCnt = 0;
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        cyc(6);
        rst = 1'b0;
        cyc(2);
        chk(stat.position, 24'h00_0000);
        chk({19'h0, irq, stat.matchFlag, stat.dirFault, stat.indexSeen, stat.turn_direction}, 24'h00_0000);
        foreach (rows[i]) begin
            cfg.pulseDivSel = rows[i].div;
            cfg.intAllow = rows[i].ia;
            start(rows[i].mode, 1'b0);
            cfg.three_phase_sel = rows[i].p3;
            for (int k = 0; k < rows[i].n; k++)
                ev(rows[i].mode == MODE_ENCODER, 1'b0, rows[i].mode == MODE_ENCODER ? 3'h0 : 3'h1 << (k % 3), 8);
            chk(stat.position, 24'(rows[i].pos));
            chk(24'(irqCnt), 24'(rows[i].irqs));
        end
        cfg.intAllow = 1'b1;
        start(MODE_ENCODER, 1'b1);
        repeat (3) ev(1'b1, 1'b0, 3'h0, 8);
        ev(1'b0, 1'b1, 3'h0, 8);
        chk(b(stat.turn_direction), 24'h00_0000);
        ev(1'b1, 1'b0, 3'h0, 8);
        chk(stat.position, 24'h00_0003);
        chk(b(stat.turn_direction), 24'h00_0001);
        cfg.run = 1'b0;
        ev(1'b1, 1'b0, 3'h0, 8);
        chk(stat.position, 24'h00_0003);
        chk(b(stat.turn_direction), 24'h00_0000);
        cfg.run = 1'b1;
        cyc(3);
        ev(1'b0, 1'b0, 3'h4, 8);
        chk(stat.position, 24'h00_0000);
        chk(b(stat.indexSeen), 24'h00_0001);
        ev(1'b0, 1'b0, 3'h4, 8);
        cfg.run = 1'b0;
        cyc(2);
        chk(b(stat.indexSeen), 24'h00_0000);
        start(MODE_ENCODER, 1'b0);
        ev(1'b0, 1'b0, 3'h3, 8);
        chk({stat.position[22:0], stat.dirFault}, 24'h00_0001);
        clr(1'b0);
        chk(b(stat.dirFault), 24'h00_0000);
        cfg.compareEn = 1'b1;
        cfg.compareValue = 24'h00_0002;
        irqCnt = 0;
        repeat (3) ev(1'b1, 1'b0, 3'h0, 8);
        chk(b(stat.matchFlag), 24'h00_0001);
        chk(24'(irqCnt), 24'h00_0004);
        clr(1'b0);
        chk(b(stat.matchFlag), 24'h00_0000);
        cfg.compareEn = 1'b0;
        clr(1'b1);
        chk(stat.position, 24'h00_0000);
        for (int c = 1; c < 4; c++) begin
            cfg.filter_width_sel = 2'(c);
            start(MODE_ENCODER, 1'b0);
            ev(1'b1, 1'b0, 3'h0, (32 << (c - 1)) - 10);
            ev(1'b0, 1'b1, 3'h0, (32 << (c - 1)) + 20);
            chk(stat.position, 24'h00_0000);
            chk(24'(irqCnt), 24'h00_0000);
            ev(1'b1, 1'b0, 3'h0, (32 << (c - 1)) + 20);
            chk(stat.position, 24'h00_0001);
            chk(24'(irqCnt), 24'h00_0001);
        end
        cfg.filter_width_sel = 2'h0;
        start(MODE_TIMER, 1'b1);
        cyc(30);
        cfg.run = 1'b0;
        cyc(2);
        hold = stat.position;
        cyc(10);
        chk(stat.position, hold);
        chk(b(hold > 24'h00_0014), 24'h00_0001);
        cfg.run = 1'b1;
        cyc(3);
        ev(1'b0, 1'b0, 3'h4, 8);
        chk(b(stat.position < 24'h00_0010), 24'h00_0001);
        chk(b(stat.indexSeen), 24'h00_0001);
        start(MODE_SENSOR_TMR, 1'b0);
        cyc(30);
        ev(1'b0, 1'b0, 3'h1, 8);
        chk(b(stat.position < 24'h00_0010), 24'h00_0001);
        stop_test();
    end
endmodule

// file: testbench/rei_encoder_model.sv
// encoder and hall sensor model driving the phase pins
`timescale 1ns/1ps
module rei_encoder_model (
    input wire logic ref_clk,
    input wire logic stepUp,
    input wire logic stepDown,
    input wire logic [2:0] toggle,
    output logic [2:0] phasePin
);
    initial phasePin = 3'h0;
    // pins move just after the falling edge, clear of the sampling edge
    always @(negedge ref_clk) begin
        #2;
        if (stepUp)
            phasePin[1:0] <= {~phasePin[0], phasePin[1]};
        else if (stepDown)
            phasePin[1:0] <= {phasePin[0], ~phasePin[1]};
        else
            phasePin <= phasePin ^ toggle;
    end
endmodule
